// [pmicsp_pkg.sv]
// Shared constants and types for the power manager control and serial port.
package pmicsp_pkg;

  // ----------------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------------
  localparam logic [6:0] SLAVE_ADDR = 7'h48;
  localparam logic [7:0] ADDR_REVISION = 8'h00;
  localparam logic [7:0] ADDR_RAIL_FAULT = 8'h01;
  localparam logic [7:0] ADDR_MASK = 8'h02;
  localparam logic [7:0] ADDR_LINREG_A = 8'h05;
  localparam logic [7:0] ADDR_LINREG_B = 8'h06;
  localparam logic [7:0] ADDR_CORE = 8'h07;
  localparam logic [7:0] UNMAPPED_READ = 8'hFF;
  // Arbitrary neutral identification value.
  localparam logic [7:0] REVISION_ID_DEFAULT = 8'h5A;

  // ----------------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------------
  localparam int BIT_SUPPLY_FAIL = 7;
  localparam int BIT_BATTERY_LOW = 6;
  localparam int BIT_RAIL_LSB = 1;
  localparam int NUM_RAILS = 5;
  localparam logic [7:0] MASK_RESET = 8'hC0;

  // Voltage settings are in tenths of a volt.
  localparam logic [7:0] VSEL_1V2 = 8'h0C;
  localparam logic [7:0] VSEL_1V3 = 8'h0D;
  localparam logic [7:0] VSEL_1V6 = 8'h10;
  localparam logic [7:0] VSEL_1V8 = 8'h12;
  localparam logic [7:0] VSEL_2V8 = 8'h1C;
  localparam logic [7:0] VSEL_3V3 = 8'h21;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned RESET_DELAY_MS = 100;
  localparam int unsigned DEBOUNCE_MS = 30;
  localparam int unsigned RESET_DELAY_CYCLES =
    RESET_DELAY_MS * (CLK_HZ / 1000);
  localparam int unsigned DEBOUNCE_CYCLES = DEBOUNCE_MS * (CLK_HZ / 1000);

  // ----------------------------------------------------------------------
  // Link states
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    LK_IDLE, LK_ADDR, LK_ADDR_ACK, LK_REG, LK_REG_ACK,
    LK_WDATA, LK_WDATA_ACK, LK_RDATA, LK_RDATA_ACK
  } pmicsp_link_st_t;

endpackage : pmicsp_pkg

// [pmicsp_top.sv]
// Power manager control logic with its serial register port.
module pmicsp_top #(
  parameter int unsigned RESET_DELAY_CYCLES = pmicsp_pkg::RESET_DELAY_CYCLES,
  parameter int unsigned DEBOUNCE_CYCLES = pmicsp_pkg::DEBOUNCE_CYCLES,
  parameter logic [7:0] REVISION_ID = pmicsp_pkg::REVISION_ID_DEFAULT
) (
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_scl_clk,
  input wire logic i_sda_in,
  output logic o_sda_o,
  output logic o_sda_oe,
  input wire logic i_lockout_below,
  input wire logic i_retention_lost,
  input wire logic i_backup_rail_good,
  input wire logic i_warm_reset_in_n,
  input wire logic i_supply_fail_sense,
  input wire logic i_battery_low_sense,
  input wire logic i_core_default_select,
  input wire logic i_linreg_a_default_sel,
  input wire logic i_linreg_b_default_sel,
  input wire logic [4:0] i_rail_enabled,
  input wire logic [4:0] i_rail_in_reg,
  output logic o_on_mode,
  output logic o_system_reset_out_o,
  output logic o_system_reset_out_oe,
  output logic o_alert_o,
  output logic o_alert_oe,
  output logic o_supply_fail_flag,
  output logic o_battery_low_flag,
  output logic [7:0] o_core_vsel,
  output logic [7:0] o_linreg_a_vsel,
  output logic [7:0] o_linreg_b_vsel
);

  // ----------------------------------------------------------------------
  // Types and helpers
  // ----------------------------------------------------------------------
  localparam int DBW = $clog2(DEBOUNCE_CYCLES + 1);
  localparam int RDW = $clog2(RESET_DELAY_CYCLES + 1);
  localparam logic [DBW-1:0] DEB_LAST = DBW'(DEBOUNCE_CYCLES - 1);
  localparam logic [RDW-1:0] RST_LAST = RDW'(RESET_DELAY_CYCLES - 1);

  typedef struct packed {
    logic [1:0] lockout, retain, backup, warm_n, sf, bl;
    logic [1:0] str_core, str_a, str_b;
    logic [4:0] en1, en2, ok1, ok2;
    logic [2:0] wr_t, ptr_t, rd_t;
    logic warm_filt;
    logic [DBW-1:0] deb_cnt;
    logic rst_active;
    logic [RDW-1:0] rst_cnt;
    logic on_mode, sf_flag, bl_flag, strap_done, powered_up, alert_oe;
    logic [7:0] mask, linreg_a, linreg_b, core, rd_byte;
    logic [6:0] released, active_prev;
  } pmicsp_sys_t;

  typedef struct packed {
    pmicsp_pkg::pmicsp_link_st_t st;
    logic [2:0] cnt;
    logic [7:0] sh, reg_addr, wr_data;
    logic rw, wr_t, ptr_t, rd_t, sda_oe;
  } pmicsp_link_t;

  pmicsp_sys_t q, d;
  pmicsp_link_t lq, ld;
  logic sda_p_q;

  function automatic logic [15:0] pmicsp_linreg_def(input logic a,
                                                    input logic b);
    logic [15:0] v;
    v = {pmicsp_pkg::VSEL_1V8, pmicsp_pkg::VSEL_3V3};
    unique case ({b, a})
      2'b00: v = {pmicsp_pkg::VSEL_1V3, pmicsp_pkg::VSEL_3V3};
      2'b01: v = {pmicsp_pkg::VSEL_2V8, pmicsp_pkg::VSEL_3V3};
      2'b10: v = {pmicsp_pkg::VSEL_1V3, pmicsp_pkg::VSEL_1V8};
      2'b11: v = {pmicsp_pkg::VSEL_1V8, pmicsp_pkg::VSEL_3V3};
    endcase
    return v;
  endfunction : pmicsp_linreg_def

  function automatic logic [7:0] pmicsp_core_def(input logic sel);
    return sel ? pmicsp_pkg::VSEL_1V6 : pmicsp_pkg::VSEL_1V2;
  endfunction : pmicsp_core_def

  // ----------------------------------------------------------------------
  // Status composition
  // ----------------------------------------------------------------------
  logic [6:0] faults;
  logic [7:0] status_byte;
  logic [6:0] active;
  logic any_en, reload_core, wr_evt, ptr_evt, rd_evt;

  always_comb begin
    faults = {q.sf_flag, q.bl_flag, q.en2 & ~q.ok2};
    status_byte = {faults, 1'b0};
    active = faults & ~q.mask[7:1];
    any_en = |q.en2;
    reload_core = q.warm_filt | ~q.backup[1] | q.lockout[1] |
                  q.rst_active;
    wr_evt = q.wr_t[1] ^ q.wr_t[2];
    ptr_evt = q.ptr_t[1] ^ q.ptr_t[2];
    rd_evt = q.rd_t[1] ^ q.rd_t[2];
  end

  // ----------------------------------------------------------------------
  // System clock domain
  // ----------------------------------------------------------------------
  always_comb begin
    logic [15:0] lr;
    logic raw_warm;
    lr = pmicsp_linreg_def(q.str_a[1], q.str_b[1]);
    raw_warm = ~q.warm_n[1];
    d = q;
    d.lockout = {q.lockout[0], i_lockout_below};
    d.retain = {q.retain[0], i_retention_lost};
    d.backup = {q.backup[0], i_backup_rail_good};
    d.warm_n = {q.warm_n[0], i_warm_reset_in_n};
    d.sf = {q.sf[0], i_supply_fail_sense};
    d.bl = {q.bl[0], i_battery_low_sense};
    d.str_core = {q.str_core[0], i_core_default_select};
    d.str_a = {q.str_a[0], i_linreg_a_default_sel};
    d.str_b = {q.str_b[0], i_linreg_b_default_sel};
    d.en1 = i_rail_enabled;
    d.en2 = q.en1;
    d.ok1 = i_rail_in_reg;
    d.ok2 = q.ok1;
    d.wr_t = {q.wr_t[1:0], lq.wr_t};
    d.ptr_t = {q.ptr_t[1:0], lq.ptr_t};
    d.rd_t = {q.rd_t[1:0], lq.rd_t};

    d.on_mode = ~q.lockout[1];
    d.sf_flag = q.sf[1];
    d.bl_flag = q.bl[1];

    // The filtered level only moves after the raw level has held steady.
    if (raw_warm == q.warm_filt) begin
      d.deb_cnt = '0;
    end else if (q.deb_cnt == DEB_LAST) begin
      d.deb_cnt = '0;
      d.warm_filt = raw_warm;
    end else begin
      d.deb_cnt = q.deb_cnt + 1'b1;
    end

    if (~q.backup[1] | q.warm_filt) begin
      d.rst_active = 1'b1;
      d.rst_cnt = '0;
    end else if (q.rst_active) begin
      if (q.rst_cnt == RST_LAST) begin
        d.rst_active = 1'b0;
      end else begin
        d.rst_cnt = q.rst_cnt + 1'b1;
      end
    end

    // Register writes from the serial port; held words are stable here.
    if (wr_evt) begin
      unique case (lq.reg_addr)
        pmicsp_pkg::ADDR_MASK: d.mask = {lq.wr_data[7:1], 1'b0};
        pmicsp_pkg::ADDR_LINREG_A: d.linreg_a = lq.wr_data;
        pmicsp_pkg::ADDR_LINREG_B: d.linreg_b = lq.wr_data;
        pmicsp_pkg::ADDR_CORE: d.core = lq.wr_data;
        default: ;
      endcase
    end
    if (reload_core) begin
      d.core = pmicsp_core_def(q.str_core[1]);
    end
    if (~q.strap_done) begin
      d.linreg_a = lr[15:8];
      d.linreg_b = lr[7:0];
      d.strap_done = 1'b1;
    end
    // Mask and linear regulator settings fall back to defaults only on i_reset or once retention is lost.
    if (q.retain[1]) begin
      d.mask = pmicsp_pkg::MASK_RESET;
      d.strap_done = 1'b0;
    end

    // Snapshot of the addressed register; refreshed per register address.
    if (ptr_evt) begin
      unique case (lq.reg_addr)
        pmicsp_pkg::ADDR_REVISION: d.rd_byte = REVISION_ID;
        pmicsp_pkg::ADDR_RAIL_FAULT: d.rd_byte = status_byte;
        pmicsp_pkg::ADDR_MASK: d.rd_byte = q.mask;
        pmicsp_pkg::ADDR_LINREG_A: d.rd_byte = q.linreg_a;
        pmicsp_pkg::ADDR_LINREG_B: d.rd_byte = q.linreg_b;
        pmicsp_pkg::ADDR_CORE: d.rd_byte = q.core;
        default: d.rd_byte = pmicsp_pkg::UNMAPPED_READ;
      endcase
    end

    // Alert pin handling.
    if (~any_en | ~q.on_mode) begin
      d.powered_up = 1'b0;
    end else if (~|(q.en2 & ~q.ok2)) begin
      d.powered_up = 1'b1;
    end
    d.active_prev = active;
    // A fault that appears in the read cycle is not in the old snapshot,
    // so it still pulls the pin low.
    d.released = (q.released |
      ((rd_evt && lq.reg_addr == pmicsp_pkg::ADDR_RAIL_FAULT &&
        q.alert_oe) ? q.active_prev : 7'h00)) & active;
    d.alert_oe = ~any_en | ~q.powered_up |
                 (|(active & ~q.released));
  end

  always_ff @(posedge i_clk) begin
    if (i_reset) begin
      q <= '0;
      // Supply, reset, flag and strap synchronisers (not the rail or toggle ones) keep sampling through reset, so those levels
      // are settled at release and no stale level looks like an event.
      q.lockout <= d.lockout;
      q.retain <= d.retain;
      q.backup <= d.backup;
      q.warm_n <= d.warm_n;
      q.sf <= d.sf;
      q.bl <= d.bl;
      q.str_core <= d.str_core;
      q.str_a <= d.str_a;
      q.str_b <= d.str_b;
      q.sf_flag <= q.sf[1];
      q.bl_flag <= q.bl[1];
      q.mask <= pmicsp_pkg::MASK_RESET;
      q.rst_active <= 1'b1;
      q.alert_oe <= 1'b1;
      q.core <= pmicsp_core_def(q.str_core[1]);
      q.rd_byte <= pmicsp_pkg::UNMAPPED_READ;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------------
  // Link domain: data sampled on the rising clock, driven on the falling
  // ----------------------------------------------------------------------
  always_ff @(posedge i_scl_clk or posedge i_reset) begin
    if (i_reset) begin
      sda_p_q <= 1'b1;
    end else begin
      sda_p_q <= i_sda_in;
    end
  end

  always_comb begin
    logic [7:0] full;
    logic start;
    full = {lq.sh[6:0], sda_p_q};
    // Data falling while the clock is high is a start; once idle, any low
    // data at a falling clock can only follow a start.
    start = (sda_p_q & ~i_sda_in) |
            (lq.st == pmicsp_pkg::LK_IDLE & ~i_sda_in);
    ld = lq;
    if (start && lq.st != pmicsp_pkg::LK_RDATA &&
        lq.st != pmicsp_pkg::LK_ADDR_ACK &&
        lq.st != pmicsp_pkg::LK_REG_ACK &&
        lq.st != pmicsp_pkg::LK_WDATA_ACK) begin
      ld.st = pmicsp_pkg::LK_ADDR;
      ld.cnt = '0;
      ld.sda_oe = 1'b0;
    end else begin
      unique case (lq.st)
        pmicsp_pkg::LK_IDLE: ld.sda_oe = 1'b0;
        pmicsp_pkg::LK_ADDR, pmicsp_pkg::LK_REG, pmicsp_pkg::LK_WDATA: begin
          ld.sh = full;
          ld.cnt = lq.cnt + 3'd1;
          if (lq.cnt == 3'd7) begin
            ld.sda_oe = 1'b1;
            if (lq.st == pmicsp_pkg::LK_ADDR) begin
              ld.rw = full[0];
              ld.st = pmicsp_pkg::LK_ADDR_ACK;
              if (full[7:1] != pmicsp_pkg::SLAVE_ADDR) begin
                ld.sda_oe = 1'b0;
                ld.st = pmicsp_pkg::LK_IDLE;
              end
            end else if (lq.st == pmicsp_pkg::LK_REG) begin
              ld.reg_addr = full;
              ld.ptr_t = ~lq.ptr_t;
              ld.st = pmicsp_pkg::LK_REG_ACK;
            end else begin
              ld.wr_data = full;
              ld.wr_t = ~lq.wr_t;
              ld.st = pmicsp_pkg::LK_WDATA_ACK;
            end
          end
        end
        pmicsp_pkg::LK_ADDR_ACK: begin
          ld.cnt = '0;
          if (lq.rw) begin
            ld.sda_oe = ~q.rd_byte[7];
            ld.sh = {q.rd_byte[6:0], 1'b0};
            ld.rd_t = ~lq.rd_t;
            ld.st = pmicsp_pkg::LK_RDATA;
          end else begin
            ld.sda_oe = 1'b0;
            ld.st = pmicsp_pkg::LK_REG;
          end
        end
        pmicsp_pkg::LK_REG_ACK: begin
          ld.sda_oe = 1'b0;
          ld.cnt = '0;
          ld.st = pmicsp_pkg::LK_WDATA;
        end
        pmicsp_pkg::LK_WDATA_ACK: begin
          ld.sda_oe = 1'b0;
          ld.st = pmicsp_pkg::LK_IDLE;
        end
        pmicsp_pkg::LK_RDATA: begin
          ld.cnt = lq.cnt + 3'd1;
          if (lq.cnt == 3'd7) begin
            ld.sda_oe = 1'b0;
            ld.st = pmicsp_pkg::LK_RDATA_ACK;
          end else begin
            ld.sda_oe = ~lq.sh[7];
            ld.sh = {lq.sh[6:0], 1'b0};
          end
        end
        pmicsp_pkg::LK_RDATA_ACK: begin
          ld.cnt = '0;
          if (~sda_p_q) begin
            ld.sda_oe = ~q.rd_byte[7];
            ld.sh = {q.rd_byte[6:0], 1'b0};
            ld.rd_t = ~lq.rd_t;
            ld.st = pmicsp_pkg::LK_RDATA;
          end else begin
            ld.sda_oe = 1'b0;
            ld.st = pmicsp_pkg::LK_IDLE;
          end
        end
        default: begin
          ld.sda_oe = 1'b0;
          ld.st = pmicsp_pkg::LK_IDLE;
        end
      endcase
    end
  end

  always_ff @(negedge i_scl_clk or posedge i_reset) begin
    if (i_reset) begin
      lq <= '0;
    end else begin
      lq <= ld;
    end
  end

  // ----------------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------------
  always_comb begin
    o_sda_o = 1'b0;
    o_sda_oe = lq.sda_oe;
    o_on_mode = q.on_mode;
    o_system_reset_out_o = 1'b0;
    o_system_reset_out_oe = q.rst_active;
    o_alert_o = 1'b0;
    o_alert_oe = q.alert_oe;
    o_supply_fail_flag = q.sf_flag;
    o_battery_low_flag = q.bl_flag;
    o_core_vsel = q.core;
    o_linreg_a_vsel = q.linreg_a;
    o_linreg_b_vsel = q.linreg_b;
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  sequence s_backup_low;
    !q.backup[1];
  endsequence

  sequence s_warm_rise;
    $rose(q.warm_filt);
  endsequence

  AST_OFF_MODE: assert property (@(posedge i_clk)
    disable iff (i_reset)
    q.lockout[1] |=> !o_on_mode)
    else $error("on mode while supply below lockout");

  AST_RESET_HELD: assert property (@(posedge i_clk)
    disable iff (i_reset)
    s_backup_low |=> o_system_reset_out_oe [*2])
    else $error("system reset released with backup rail low");

  AST_RESET_OPEN_DRAIN: assert property (@(posedge i_clk)
    disable iff (i_reset) !o_system_reset_out_o)
    else $error("system reset driven high");

  AST_WARM_RESET: assert property (@(posedge i_clk)
    disable iff (i_reset)
    s_warm_rise |=> o_system_reset_out_oe ##1 o_system_reset_out_oe)
    else $error("warm reset did not assert system reset");

  AST_FLAGS: assert property (@(posedge i_clk)
    disable iff (i_reset)
    ##1 (o_supply_fail_flag == $past(q.sf[1])) &&
        (o_battery_low_flag == $past(q.bl[1])))
    else $error("flag does not follow its comparator");

  AST_CORE_RELOAD: assert property (@(posedge i_clk)
    disable iff (i_reset)
    reload_core |=> o_core_vsel == pmicsp_core_def($past(q.str_core[1])))
    else $error("core setting not restored to strap default");

  AST_NO_RAIL_ALERT: assert property (@(posedge i_clk)
    disable iff (i_reset)
    !any_en |=> o_alert_oe)
    else $error("alert released with no rail enabled");

  AST_FAULT_STATUS: assert property (@(posedge i_clk)
    disable iff (i_reset)
    status_byte[5:1] == (q.en2 & ~q.ok2) && !status_byte[0])
    else $error("fault status layout broken");

  AST_MASK_RESET: assert property (@(posedge i_clk)
    $past(i_reset) |-> q.mask == pmicsp_pkg::MASK_RESET)
    else $error("mask register reset value wrong");

  AST_ADDR_ACK: assert property (@(negedge i_scl_clk)
    disable iff (i_reset)
    lq.st == pmicsp_pkg::LK_ADDR_ACK |-> lq.sda_oe)
    else $error("address not acknowledged");

  AST_NACK_RELEASE: assert property (@(negedge i_scl_clk)
    disable iff (i_reset)
    (lq.st == pmicsp_pkg::LK_RDATA_ACK && sda_p_q) |=>
      (!lq.sda_oe && lq.st == pmicsp_pkg::LK_IDLE))
    else $error("data line held after master withheld acknowledge");

endmodule : pmicsp_top

// [pmicsp_host_model.sv]
// Behavioural serial bus master standing in for the host processor.
module pmicsp_host_model (
  output logic o_scl,
  output logic o_sda_low,
  input wire logic i_sda
);
  timeunit 1ns;
  timeprecision 100ps;
  logic ack_seen;
  initial begin
    o_scl = 1'b1;
    o_sda_low = 1'b0;
    ack_seen = 1'b0;
  end
  // ----------------------------------------------------------------------
  // Bit level
  // ----------------------------------------------------------------------
  // One 80 ns bit; data moves only while the clock is low.
  task automatic bit_io(input logic b, output logic r);
    #20 o_sda_low = ~b;
    #20 o_scl = 1'b1;
    #20 r = i_sda;
    #20 o_scl = 1'b0;
  endtask : bit_io
  // Start or repeated start; the clock rests high outside frames.
  task automatic start_c;
    #20 o_sda_low = 1'b0;
    #20 o_scl = 1'b1;
    #20 o_sda_low = 1'b1;
    #20 o_scl = 1'b0;
  endtask : start_c
  // The long idle after a stop gives the slave time to settle.
  task automatic stop_c;
    #20 o_sda_low = 1'b1;
    #20 o_scl = 1'b1;
    #20 o_sda_low = 1'b0;
    #2000;
  endtask : stop_c
  task automatic send(input logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'b1, r);
    ack_seen = ~r;
  endtask : send
  // A single byte is read, so the acknowledge is withheld.
  task automatic recv(output logic [7:0] v);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, r);
      v[i] = r;
    end
    bit_io(1'b1, r);
  endtask : recv
  // ----------------------------------------------------------------------
  // Transactions
  // ----------------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d,
                    input logic [6:0] dev = pmicsp_pkg::SLAVE_ADDR);
    start_c();
    send({dev, 1'b0});
    send(a);
    send(d);
    stop_c();
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    start_c();
    send({pmicsp_pkg::SLAVE_ADDR, 1'b0});
    send(a);
    #2000;
    start_c();
    send({pmicsp_pkg::SLAVE_ADDR, 1'b1});
    recv(d);
    stop_c();
  endtask : rd
endmodule : pmicsp_host_model

// [tb.sv]
// Self-checking testbench for the power manager control and serial port.
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, reset, lockout, ret_lost, bk_good, warm_n, sf, bl;
  logic core_sel, a_sel, b_sel, scl, host_low, sda_o, sda_oe, on_mode;
  logic rst_o, rst_oe, alert_o, alert_oe, sf_flag, bl_flag;
  logic [4:0] en, inreg;
  logic [7:0] core_v, lra_v, lrb_v, rd_v, w_v, w_a;
  wire sda_line;
  int n_mismatch = 0;
  int comparisons = 0;
  int cyc = 0;
  int seed;
  // The data line has a pull-up, so a released line reads high.
  assign sda_line = !((sda_oe && !sda_o) || host_low);
  pmicsp_top #(.RESET_DELAY_CYCLES(20), .DEBOUNCE_CYCLES(8)) pmicsp_top_i (
    .i_clk(clk), .i_reset(reset), .i_scl_clk(scl), .i_sda_in(sda_line),
    .o_sda_o(sda_o), .o_sda_oe(sda_oe), .i_lockout_below(lockout),
    .i_retention_lost(ret_lost), .i_backup_rail_good(bk_good),
    .i_warm_reset_in_n(warm_n), .i_supply_fail_sense(sf),
    .i_battery_low_sense(bl), .i_core_default_select(core_sel),
    .i_linreg_a_default_sel(a_sel), .i_linreg_b_default_sel(b_sel),
    .i_rail_enabled(en), .i_rail_in_reg(inreg), .o_on_mode(on_mode),
    .o_system_reset_out_o(rst_o), .o_system_reset_out_oe(rst_oe),
    .o_alert_o(alert_o), .o_alert_oe(alert_oe), .o_supply_fail_flag(sf_flag),
    .o_battery_low_flag(bl_flag), .o_core_vsel(core_v),
    .o_linreg_a_vsel(lra_v), .o_linreg_b_vsel(lrb_v));
  pmicsp_host_model pmicsp_host_model_i (
    .o_scl(scl), .o_sda_low(host_low), .i_sda(sda_line));
  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  task automatic end_of_test;
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_mismatch++;
      end_of_test();
    end
  end
  task automatic chk(input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      n_mismatch++;
      $display("[FAIL] %0t exp %h got %h", $time, e, g);
    end
  endtask : chk
  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask : wait_n
  function automatic logic [7:0] exp_lr(input logic [1:0] s, input logic b);
    if (b) return (s == 2'b10) ? pmicsp_pkg::VSEL_1V8 : pmicsp_pkg::VSEL_3V3;
    if (s == 2'b01) return pmicsp_pkg::VSEL_2V8;
    return (s == 2'b11) ? pmicsp_pkg::VSEL_1V8 : pmicsp_pkg::VSEL_1V3;
  endfunction : exp_lr
  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  initial begin
    seed = 32'h8aca_3bea;
    {reset, lockout, ret_lost, bk_good, warm_n, sf, bl} = 7'b1100100;
    {core_sel, a_sel, b_sel} = 3'($random(seed));
    en = 5'h00;
    inreg = 5'h00;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    wait_n(6);
    chk(8'h00, on_mode);
    chk(8'h01, rst_oe);
    chk(8'h01, alert_oe);
    chk(core_sel ? 8'h10 : 8'h0C, core_v);
    @(posedge clk);
    lockout <= 1'b0;
    bk_good <= 1'b1;
    wait_n(10);
    chk(8'h01, on_mode);
    chk(8'h01, rst_oe);
    wait_n(20);
    chk(8'h00, rst_oe);
    chk(8'h00, rst_o);
    for (int s = 0; s < 4; s++) begin
      @(posedge clk);
      {b_sel, a_sel} <= s[1:0];
      ret_lost <= 1'b1;
      repeat (3) @(posedge clk);
      ret_lost <= 1'b0;
      wait_n(6);
      chk(exp_lr(s[1:0], 1'b0), lra_v);
      chk(exp_lr(s[1:0], 1'b1), lrb_v);
    end
    pmicsp_host_model_i.rd(pmicsp_pkg::ADDR_REVISION, rd_v);
    chk(pmicsp_pkg::REVISION_ID_DEFAULT, rd_v);
    chk(8'h01, pmicsp_host_model_i.ack_seen);
    pmicsp_host_model_i.wr(pmicsp_pkg::ADDR_REVISION, 8'h00);
    pmicsp_host_model_i.rd(pmicsp_pkg::ADDR_REVISION, rd_v);
    chk(pmicsp_pkg::REVISION_ID_DEFAULT, rd_v);
    pmicsp_host_model_i.rd(pmicsp_pkg::ADDR_MASK, rd_v);
    chk(pmicsp_pkg::MASK_RESET, rd_v);
    for (int k = 0; k < 2; k++) begin
      w_v = k ? (8'h08 | 8'($random(seed))) : 8'h03;
      pmicsp_host_model_i.rd(w_v, rd_v);
      chk(pmicsp_pkg::UNMAPPED_READ, rd_v);
      w_v = 8'($random(seed));
      pmicsp_host_model_i.wr(k ? 8'h06 : 8'h05, w_v);
      wait_n(8);
      chk(w_v, k ? lrb_v : lra_v);
      pmicsp_host_model_i.rd(k ? 8'h06 : 8'h05, rd_v);
      chk(w_v, rd_v);
      if (k == 0) w_a = w_v;
    end
    w_v = 8'($random(seed));
    pmicsp_host_model_i.wr(pmicsp_pkg::ADDR_CORE, w_v);
    @(posedge clk);
    warm_n <= 1'b0;
    repeat (3) @(posedge clk);
    warm_n <= 1'b1;
    wait_n(6);
    chk(8'h00, rst_oe);
    chk(w_v, core_v);
    @(posedge clk);
    warm_n <= 1'b0;
    wait_n(16);
    chk(8'h01, rst_oe);
    chk(core_sel ? 8'h10 : 8'h0C, core_v);
    chk(w_a, lra_v);
    @(posedge clk);
    warm_n <= 1'b1;
    wait_n(40);
    chk(8'h00, rst_oe);
    w_v = 8'($random(seed));
    pmicsp_host_model_i.wr(pmicsp_pkg::ADDR_MASK, 8'h00,
                           pmicsp_pkg::SLAVE_ADDR ^ {w_v[5:0], 1'b1});
    chk(8'h00, pmicsp_host_model_i.ack_seen);
    pmicsp_host_model_i.rd(pmicsp_pkg::ADDR_MASK, rd_v);
    chk(pmicsp_pkg::MASK_RESET, rd_v);
    for (int s = 1; s < 3; s++) begin
      @(posedge clk);
      {sf, bl} <= s[1:0];
      wait_n(6);
      chk(s[1:0], {sf_flag, bl_flag});
    end
    @(posedge clk);
    en <= 5'h1F;
    inreg <= 5'h1F;
    wait_n(6);
    chk(8'h00, alert_oe);
    @(posedge clk);
    inreg <= 5'h1D;
    wait_n(6);
    chk(8'h01, alert_oe);
    chk(8'h00, alert_o);
    for (int k = 0; k < 2; k++) begin
      pmicsp_host_model_i.rd(pmicsp_pkg::ADDR_RAIL_FAULT, rd_v);
      chk({sf, bl, en & ~inreg, 1'b0}, rd_v);
      chk(8'h00, alert_oe);
    end
    @(posedge clk);
    inreg <= 5'h1F;
    pmicsp_host_model_i.wr(pmicsp_pkg::ADDR_MASK, 8'hC4);
    @(posedge clk);
    inreg <= 5'h1D;
    wait_n(6);
    chk(8'h00, alert_oe);
    @(posedge clk);
    lockout <= 1'b1;
    wait_n(6);
    chk(8'h00, on_mode);
    chk(8'h01, alert_oe);
    @(posedge clk);
    lockout <= 1'b0;
    pmicsp_host_model_i.rd(pmicsp_pkg::ADDR_MASK, rd_v);
    chk(8'hC4, rd_v);
    @(posedge clk);
    en <= 5'h00;
    wait_n(6);
    chk(8'h01, alert_oe);
    end_of_test();
  end
endmodule : tb
